/* File: verilog/pft_fault_top.sv */
// fault turn-off, status and OK line propagation of a POL converter
`timescale 1ns/1ps
`include "pft_cfg.svh"
module pft_fault_top
  import pft_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = `PFT_HICCUP_MS * `PFT_CLK_KHZ
)
(
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  // register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // fault detector levels, high while the condition is present
  input  wire logic       TEMP_WARN,
  input  wire logic       PWR_GOOD_WARN,
  input  wire logic       TRACK_FAULT,
  input  wire logic       OVER_TEMP,
  input  wire logic       OVER_CURR,
  input  wire logic       UNDER_VOLT,
  input  wire logic       OVER_VOLT,
  // manager sync line and shared open-drain OK line
  input  wire logic       SD_LINE,
  input  wire logic       OK_IN,
  output logic            OK_OUT,
  output logic            OK_OE,
  // power stage control
  output logic            OUTPUT_ON,
  output logic            RAMP_DOWN,
  output logic            HS_DRIVE_EN,
  output logic            LS_DRIVE_EN,
  output logic            LS_FORCE_ON
);

  localparam logic [`PFT_CNT_W-1:0] HICCUP_LAST =
    `PFT_CNT_W'(HICCUP_CYCLES - 1);

  // pin synchronisers
  logic [`PFT_SYNC_W-1:0] pin_raw;
  logic [`PFT_SYNC_W-1:0] pin_s1;
  logic [`PFT_SYNC_W-1:0] pin_s2;
  logic [`PFT_SYNC_W-1:0] pin_s3;
  logic [`PFT_SYNC_W-1:0] pin_flt;
  logic [`PFT_SYNC_W-1:0] next_flt;
  logic                   sd_prev;

  // register file
  logic [7:0]             prop_en;
  logic [5:0]             style_cfg;
  logic [7:0]             latch_cfg;
  logic [7:0]             held;
  logic [7:0]             next_held;
  logic [7:0]             rd_mux;

  // core state
  pft_core_t              state;
  pft_core_t              next_state;
  pft_style_t             style;
  pft_style_t             next_style;
  logic                   prop_on;
  logic                   next_prop;
  logic [`PFT_CNT_W-1:0]  cnt;
  logic [`PFT_CNT_W-1:0]  next_cnt;

  // decoded terms
  logic [7:0]             act;
  logic [7:0]             act_f;
  logic [7:0]             clr_wr;
  logic [7:0]             clr_hiccup;
  logic                   wr_prop;
  logic                   wr_stat;
  logic                   wr_style;
  logic                   wr_latch;
  logic                   trip_own;
  logic                   prop_hit;
  logic                   cnt_done;
  logic                   all_clear;
  pft_style_t             own_style;
  pft_style_t             sty_ot;
  pft_style_t             sty_uv;
  pft_style_t             sty_ov;
  logic                   next_on;
  logic                   next_seq;
  logic                   next_emrg;

  pft_ok_if ok ();

  pft_ok_codec u_codec (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ok    (ok.codec)
  );

  // three stages; a level counts once stages two and three agree
  assign pin_raw  = {SD_LINE, TEMP_WARN, PWR_GOOD_WARN, TRACK_FAULT,
                     OVER_TEMP, OVER_CURR, UNDER_VOLT, OVER_VOLT, OK_IN};
  assign next_flt = (pin_s2 & pin_s3) | (pin_flt & (pin_s2 ^ pin_s3));

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1  <= '0;
      pin_s2  <= '0;
      pin_s3  <= '0;
      pin_flt <= '0;
      sd_prev <= 1'b0;
    end else begin
      pin_s1  <= pin_raw;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_flt <= next_flt;
      sd_prev <= pin_flt[`PFT_PIN_SD];
    end
  end

  assign ok.sd_fall  = sd_prev & ~pin_flt[`PFT_PIN_SD];
  assign ok.sd_rise  = ~sd_prev & pin_flt[`PFT_PIN_SD];
  assign ok.ok_level = pin_flt[`PFT_PIN_OK];
  assign ok.tx_req   = prop_on;
  assign ok.tx_style = style;

  // detector levels laid out in status bit positions
  assign act   = {pin_flt[7:1], 1'b0};
  assign act_f = act & `PFT_FAULT_MASK;

  // register decode
  assign wr_prop  = REG_WR && REG_ADDR == `PFT_ADDR_PROP;
  assign wr_stat  = REG_WR && REG_ADDR == `PFT_ADDR_STAT;
  assign wr_style = REG_WR && REG_ADDR == `PFT_ADDR_STYLE;
  assign wr_latch = REG_WR && REG_ADDR == `PFT_ADDR_LATCH;

  // per-type style; tracking and over-current are always critical
  assign sty_ot = style_cfg[`PFT_OT_STY];
  assign sty_uv = style_cfg[`PFT_UV_STY];
  assign sty_ov = style_cfg[`PFT_OV_STY];
  assign own_style =
    pft_worse(
      pft_worse(act_f[`PFT_BIT_OT] ? sty_ot : `PFT_STY_SEQ,
                act_f[`PFT_BIT_UV] ? sty_uv : `PFT_STY_SEQ),
      pft_worse(act_f[`PFT_BIT_OV] ? sty_ov : `PFT_STY_SEQ,
                (act_f[`PFT_BIT_TR] | act_f[`PFT_BIT_OC]) ?
                  `PFT_STY_CRIT : `PFT_STY_SEQ));

  assign trip_own = |act_f;
  assign prop_hit = |(act_f & prop_en & `PFT_FAULT_MASK);
  assign cnt_done = cnt == HICCUP_LAST;

  // write-one clears; a detector still active sets it again (set wins)
  assign clr_wr     = wr_stat ? REG_WDATA & `PFT_FAULT_MASK : 8'h00;
  assign clr_hiccup = (state == CORE_OFF && cnt_done) ?
                      ~latch_cfg & ~act_f & `PFT_FAULT_MASK : 8'h00;
  assign next_held  = ((held & ~clr_wr & ~clr_hiccup) | act_f) &
                      `PFT_FAULT_MASK;
  assign all_clear  = ~|next_held && !trip_own;

  always_comb begin
    next_state = state;
    next_style = style;
    next_prop  = prop_on;
    next_cnt   = cnt;
    case (state)
      CORE_RUN: begin
        next_cnt = '0;
        if (trip_own) begin
          next_state = CORE_OFF;
          next_style = own_style;
          next_prop  = prop_hit;
        end else if (ok.rx_valid) begin
          next_state = CORE_OFF;
          next_style = ok.rx_style;
          next_prop  = 1'b0;
        end
      end
      CORE_OFF: begin
        next_cnt = cnt + 1'b1;
        if (trip_own && prop_hit)
          next_prop = 1'b1;
        // retry interval restarts while any cause remains
        if (cnt_done) begin
          next_cnt = '0;
          if (all_clear) begin
            next_state = CORE_RELEASE;
            next_prop  = 1'b0;
          end
        end
      end
      CORE_RELEASE: begin
        // wait for the shared line to float high before restarting
        if (trip_own) begin
          next_state = CORE_OFF;
          next_style = own_style;
          next_prop  = prop_hit;
          next_cnt   = '0;
        end else if (ok.ok_level && !ok.tx_busy) begin
          next_state = CORE_RUN;
        end
      end
      default: begin
        next_state = CORE_RUN;
        next_prop  = 1'b0;
      end
    endcase
  end

  // output drives follow the next state so they move with it
  assign next_on   = next_state == CORE_RUN;
  assign next_seq  = !next_on && next_style == `PFT_STY_SEQ;
  assign next_emrg = !next_on && next_style == `PFT_STY_EMRG;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state       <= CORE_RUN;
      style       <= `PFT_STY_SEQ;
      prop_on     <= 1'b0;
      cnt         <= '0;
      held        <= 8'h00;
      OUTPUT_ON   <= 1'b0;
      RAMP_DOWN   <= 1'b0;
      HS_DRIVE_EN <= 1'b0;
      LS_DRIVE_EN <= 1'b0;
      LS_FORCE_ON <= 1'b0;
    end else begin
      state       <= next_state;
      style       <= next_style;
      prop_on     <= next_prop;
      cnt         <= next_cnt;
      held        <= next_held;
      OUTPUT_ON   <= next_on;
      RAMP_DOWN   <= next_seq;
      HS_DRIVE_EN <= next_on | next_seq;
      LS_DRIVE_EN <= next_on | next_seq | next_emrg;
      LS_FORCE_ON <= next_emrg;
    end
  end

  // software registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prop_en   <= `PFT_PROP_RST;
      style_cfg <= `PFT_STYLE_RST;
      latch_cfg <= `PFT_LATCH_RST;
    end else begin
      if (wr_prop)
        prop_en <= REG_WDATA & `PFT_PROP_MASK;
      if (wr_style)
        style_cfg <= REG_WDATA[5:0];
      if (wr_latch)
        latch_cfg <= REG_WDATA & `PFT_FAULT_MASK;
    end
  end

  // read mux; unmapped addresses return zero
  always_comb begin
    case (REG_ADDR)
      `PFT_ADDR_PROP:  rd_mux = prop_en & `PFT_PROP_MASK;
      `PFT_ADDR_STAT:  rd_mux = {~act[`PFT_BIT_TW], ~act[`PFT_BIT_PG],
                                 ~held[5:1], `PFT_RSVD_READ};
      `PFT_ADDR_STYLE: rd_mux = {2'h0, style_cfg};
      `PFT_ADDR_LATCH: rd_mux = latch_cfg;
      `PFT_ADDR_STATE: rd_mux = {2'h0, ok.tx_busy, prop_on, style,
                                 state};
      default:         rd_mux = 8'h00;
    endcase
  end

  // the line itself is only ever pulled low; the codec times the enable
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
      OK_OUT    <= 1'b0;
      OK_OE     <= 1'b0;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 8'h00;
      OK_OUT    <= 1'b0;
      OK_OE     <= ok.ok_drive;
    end
  end

endmodule : pft_fault_top

/* File: verilog/pft_cfg.svh */
// constants for the point-of-load fault turn-off and propagation block
// Overview of operation
// - turn-off style selectable for OT, UV, OV
// - sequenced style ramps down at falling rate
// - critical style drops both switch drives
// - emergency drops high side, forces low side
// - 8-bit status register, fixed bit layout
// - active fault reads as zero
// - propagated fault pulls OK line low
// - OK low from others: same-style turn-off
// - style coded on OK high-to-low transition
// - OK changes only at SD falling edge
// - signal on OK only if enabled
// - one propagation enable bit per fault
// - propagation bits 7:6 read zero
// - non-latching fault retries every 130 ms
`ifndef PFT_CFG_SVH
`define PFT_CFG_SVH

`define PFT_ADDR_PROP   8'h02
`define PFT_ADDR_STAT   8'h16
`define PFT_ADDR_STYLE  8'h20
`define PFT_ADDR_LATCH  8'h21
`define PFT_ADDR_STATE  8'h22

`define PFT_PROP_RST    8'h3f
`define PFT_PROP_MASK   8'h3f
`define PFT_FAULT_MASK  8'h3e
`define PFT_STYLE_RST   6'h20
`define PFT_LATCH_RST   8'h00
`define PFT_RSVD_READ   1'h1

`define PFT_STY_SEQ     2'h0
`define PFT_STY_CRIT    2'h1
`define PFT_STY_EMRG    2'h2

`define PFT_BIT_TW      7
`define PFT_BIT_PG      6
`define PFT_BIT_TR      5
`define PFT_BIT_OT      4
`define PFT_BIT_OC      3
`define PFT_BIT_UV      2
`define PFT_BIT_OV      1
`define PFT_OT_STY      1:0
`define PFT_UV_STY      3:2
`define PFT_OV_STY      5:4

`define PFT_SYNC_W      9
`define PFT_PIN_SD      8
`define PFT_PIN_OK      0
`define PFT_CNT_W       23
`define PFT_HICCUP_MS   130
`define PFT_CLK_KHZ     50000

`endif

/* File: verilog/pft_pkg.sv */
// types and shared helpers for the fault turn-off block
`include "pft_cfg.svh"
package pft_pkg;

  typedef logic [1:0] pft_style_t;
  typedef enum logic [1:0] {CORE_RUN, CORE_OFF, CORE_RELEASE} pft_core_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_BIT1, TX_BIT0,
                            TX_HOLD} pft_tx_t;
  typedef enum logic [1:0] {RX_ARM, RX_BIT1, RX_BIT0, RX_DONE} pft_rx_t;

  // harsher of two styles: emergency over critical over sequenced
  function automatic pft_style_t pft_worse(input pft_style_t a,
                                           input pft_style_t b);
    if (a == `PFT_STY_EMRG || b == `PFT_STY_EMRG)
      return `PFT_STY_EMRG;
    if (a == `PFT_STY_CRIT || b == `PFT_STY_CRIT)
      return `PFT_STY_CRIT;
    return `PFT_STY_SEQ;
  endfunction : pft_worse

endpackage : pft_pkg

/* File: verilog/pft_ok_if.sv */
// carrier between the fault core and the OK line codec
`timescale 1ns/1ps
interface pft_ok_if;
  import pft_pkg::*;
  logic       sd_fall;
  logic       sd_rise;
  logic       ok_level;
  logic       tx_req;
  pft_style_t tx_style;
  logic       tx_busy;
  logic       ok_drive;
  logic       rx_valid;
  pft_style_t rx_style;

  modport core  (output sd_fall, sd_rise, ok_level, tx_req, tx_style,
                 input  tx_busy, ok_drive, rx_valid, rx_style);
  modport codec (input  sd_fall, sd_rise, ok_level, tx_req, tx_style,
                 output tx_busy, ok_drive, rx_valid, rx_style);
endinterface : pft_ok_if

/* File: verilog/pft_ok_codec.sv */
// OK line encoder and decoder, stepped by the SD sync line
`timescale 1ns/1ps
`include "pft_cfg.svh"
module pft_ok_codec
  import pft_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core side
  pft_ok_if.codec  ok
);

  pft_tx_t    tx_state, next_tx_state;
  pft_rx_t    rx_state, next_rx_state;
  pft_style_t tx_code;
  pft_style_t rx_code;
  logic       next_drive;
  logic       drive;
  logic       valid;

  // frame: start slot low, then style bits msb first (1 = released),
  // then low for as long as the fault is propagated
  always_comb begin
    next_tx_state = tx_state;
    next_drive    = drive;
    if (ok.sd_fall) begin
      case (tx_state)
        TX_IDLE: if (ok.tx_req) begin
          next_tx_state = TX_START;
          next_drive    = 1'b1;
        end
        TX_START: begin
          next_tx_state = TX_BIT1;
          next_drive    = ~tx_code[1];
        end
        TX_BIT1: begin
          next_tx_state = TX_BIT0;
          next_drive    = ~tx_code[0];
        end
        TX_BIT0: begin
          next_tx_state = TX_HOLD;
          next_drive    = 1'b1;
        end
        TX_HOLD: if (!ok.tx_req) begin
          next_tx_state = TX_IDLE;
          next_drive    = 1'b0;
        end
        default: next_tx_state = TX_IDLE;
      endcase
    end
  end

  // sampled mid-slot on SD rise; own frames are not decoded
  always_comb begin
    next_rx_state = rx_state;
    if (tx_state != TX_IDLE) begin
      next_rx_state = RX_DONE;
    end else if (ok.sd_rise) begin
      case (rx_state)
        RX_ARM:  if (!ok.ok_level) next_rx_state = RX_BIT1;
        RX_BIT1: next_rx_state = RX_BIT0;
        RX_BIT0: next_rx_state = RX_DONE;
        RX_DONE: if (ok.ok_level) next_rx_state = RX_ARM;
        default: next_rx_state = RX_DONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      rx_state <= RX_DONE;
      drive    <= 1'b0;
      tx_code  <= `PFT_STY_SEQ;
      rx_code  <= `PFT_STY_SEQ;
      valid    <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      rx_state <= next_rx_state;
      drive    <= next_drive;
      if (tx_state == TX_IDLE)
        tx_code <= ok.tx_style;
      if (ok.sd_rise && rx_state == RX_BIT1)
        rx_code[1] <= ok.ok_level;
      if (ok.sd_rise && rx_state == RX_BIT0)
        rx_code[0] <= ok.ok_level;
      valid <= ok.sd_rise && rx_state == RX_BIT0 && tx_state == TX_IDLE;
    end
  end

  assign ok.tx_busy  = tx_state != TX_IDLE;
  assign ok.ok_drive = drive;
  assign ok.rx_valid = valid;
  assign ok.rx_style = rx_code;

endmodule : pft_ok_codec

/* File: test/pft_fault_chk_sva.sv */
// concurrent checks on the ports of the fault turn-off block
`timescale 1ns/1ps
module pft_fault_chk (
  // clock, reset, register port
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // detectors and lines
  input wire logic       OVER_VOLT,
  input wire logic       UNDER_VOLT,
  input wire logic       SD_LINE,
  input wire logic       OK_OUT,
  input wire logic       OK_OE,
  // power stage
  input wire logic       OUTPUT_ON,
  input wire logic       RAMP_DOWN,
  input wire logic       HS_DRIVE_EN,
  input wire logic       LS_DRIVE_EN,
  input wire logic       LS_FORCE_ON
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic       sync_q;
  logic [3:0] since_fall;
  // saturates so an idle line never wraps into the legal window
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_q     <= 1'h0;
      since_fall <= 4'hf;
    end else begin
      sync_q     <= SD_LINE;
      since_fall <= (sync_q && !SD_LINE) ? 4'h0 :
                    (since_fall == 4'hf) ? 4'hf : since_fall + 4'h1;
    end
  end
  chk_emrg_low_side: assert property (LS_FORCE_ON |->
    !HS_DRIVE_EN && LS_DRIVE_EN) else $error("force without low drive");
  chk_crit_all_off: assert property ((!HS_DRIVE_EN && !LS_FORCE_ON)
    |-> !LS_DRIVE_EN) else $error("low side left on");
  chk_seq_ramp: assert property (RAMP_DOWN |-> HS_DRIVE_EN &&
    LS_DRIVE_EN && !OUTPUT_ON) else $error("ramp with drives cut");
  chk_fault_turns_off: assert property (OVER_VOLT[*8] |-> !OUTPUT_ON)
    else $error("output on under a lasting fault");
  chk_status_low: assert property (UNDER_VOLT[*6] ##1 (UNDER_VOLT &&
    REG_RD && REG_ADDR == 8'h16) |=> !REG_RDATA[2])
    else $error("active fault reads as one");
  chk_ok_at_fall: assert property ($changed(OK_OE) |->
    since_fall >= 4'h3 && since_fall <= 4'h7) else $error("ok moved off fall");
  chk_open_drain: assert property (!OK_OUT)
    else $error("ok data driven high");
  chk_rdata_idle: assert property (!$past(REG_RD) |->
    REG_RDATA == 8'h00) else $error("read data outside its cycle");
  chk_prop_top_zero: assert property ((REG_RD && REG_ADDR == 8'h02)
    |=> REG_RDATA[7:6] == 2'h0) else $error("unused bits read one");
  cover property (LS_FORCE_ON);
  cover property (RAMP_DOWN);
  cover property ($rose(OK_OE));
endmodule : pft_fault_chk

bind pft_fault_top pft_fault_chk chk_u (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .OVER_VOLT(OVER_VOLT), .UNDER_VOLT(UNDER_VOLT),
  .SD_LINE(SD_LINE), .OK_OUT(OK_OUT), .OK_OE(OK_OE),
  .OUTPUT_ON(OUTPUT_ON), .RAMP_DOWN(RAMP_DOWN), .HS_DRIVE_EN(HS_DRIVE_EN),
  .LS_DRIVE_EN(LS_DRIVE_EN), .LS_FORCE_ON(LS_FORCE_ON));

/* File: test/pft_mgr_model.sv */
// manager and peer converter on the sync line and shared ok wire
`timescale 1ns/1ps
module pft_mgr_model (
  // sync clock made here
  output logic       sync_line,
  // shared wire
  input  wire logic  ok_wire,
  output logic       peer_pull,
  // frames seen on the wire
  output logic [1:0] rx_style,
  output int         rx_cnt
);
  logic prev = 1'h1;
  int   phase = 0;
  initial sync_line = 1'h1;
  initial peer_pull = 1'h0;
  initial rx_cnt = 0;
  // free running, as the real sync clock also paces switching
  always #80 sync_line = ~sync_line;
  always @(posedge sync_line) begin
    case (phase)
      1: begin
        rx_style[1] = ok_wire;
        phase = 2;
      end
      2: begin
        rx_style[0] = ok_wire;
        rx_cnt++;
        phase = 0;
        prev = 1'h0;
      end
      default: begin
        if (prev && !ok_wire)
          phase = 1;
        prev = ok_wire;
      end
    endcase
  end
  task automatic send_frame(input logic [1:0] sty);
    @(negedge sync_line) peer_pull <= 1'h1;
    @(negedge sync_line) peer_pull <= ~sty[1];
    @(negedge sync_line) peer_pull <= ~sty[0];
    @(negedge sync_line) peer_pull <= 1'h1;
  endtask : send_frame
  task automatic release_line();
    @(negedge sync_line) peer_pull <= 1'h0;
  endtask : release_line
endmodule : pft_mgr_model

/* File: test/pft_fault_top_test.sv */
// self-checking bench for the fault turn-off block
`timescale 1ns/1ps
`include "pft_cfg.svh"
module pft_fault_top_test
  import pft_pkg::*;
;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  addr, wdata, det;
  logic        wr, rd;
  wire logic [7:0] rdata;
  wire logic [4:0] pwr;
  wire logic   ok_out, ok_oe, sync_line, peer_pull;
  wire logic   ok_wire = !(ok_oe && !ok_out) && !peer_pull;
  wire logic [1:0] rx_style;
  int          rx_cnt, fail_count, total_checks, n, c0, b;
  int unsigned seed = 54;
  int unsigned r;
  logic [5:0]  sty_m;
  logic [7:0]  prop_m;
  int          order[$] = '{5, 4, 3, 2, 1};
  always #10 clk = ~clk;
  pft_fault_top #(.HICCUP_CYCLES(64)) dut_u (
    .SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TEMP_WARN(det[7]),
    .PWR_GOOD_WARN(det[6]), .TRACK_FAULT(det[5]), .OVER_TEMP(det[4]),
    .OVER_CURR(det[3]), .UNDER_VOLT(det[2]), .OVER_VOLT(det[1]),
    .SD_LINE(sync_line), .OK_IN(ok_wire), .OK_OUT(ok_out), .OK_OE(ok_oe),
    .OUTPUT_ON(pwr[4]), .RAMP_DOWN(pwr[3]), .HS_DRIVE_EN(pwr[2]),
    .LS_DRIVE_EN(pwr[1]), .LS_FORCE_ON(pwr[0]));
  pft_mgr_model mgr_u (.sync_line(sync_line), .ok_wire(ok_wire),
    .peer_pull(peer_pull), .rx_style(rx_style), .rx_cnt(rx_cnt));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [4:0] pwr_of(input pft_style_t s);
    return (s == `PFT_STY_SEQ) ? 5'h0e : (s == `PFT_STY_CRIT) ? 5'h00 : 5'h03;
  endfunction : pwr_of
  // tracking and over-current have no style choice
  function automatic pft_style_t style_of(input int f);
    case (f)
      4: return sty_m[1:0];
      2: return sty_m[3:2];
      1: return sty_m[5:4];
      default: return `PFT_STY_CRIT;
    endcase
  endfunction : style_of
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic tally(input bit bad, input string what);
    total_checks++;
    if (bad) begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : tally
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    tally(g !== e, "register value");
  endtask : cmp_reg
  task automatic cmp_pwr(input logic [4:0] g, input logic [4:0] e);
    tally(g !== e, "power stage outputs");
  endtask : cmp_pwr
  task automatic cmp_sty(input logic [1:0] g, input logic [1:0] e);
    tally(g !== e, "style on ok wire");
  endtask : cmp_sty
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask : wr8
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    cmp_reg(rdata, e);
    @(posedge clk);
  endtask : rd8
  // starts off the edge so a value about to be launched is not seen as old
  task automatic wait_pwr(input logic [4:0] e, input int lim);
    n = 0;
    #1;
    while (pwr !== e && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_pwr(pwr, e);
    if (pwr !== e)
      give_verdict();
  endtask : wait_pwr
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    det = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd8(`PFT_ADDR_PROP, 8'h3f);
    rd8(`PFT_ADDR_STAT, 8'hff);
    rd8(8'h55, 8'h00);
    rd8(8'h20, 8'h20);
    rd8(8'h21, 8'h00);
    wr8(`PFT_ADDR_PROP, 8'hff);
    rd8(`PFT_ADDR_PROP, 8'h3f);
    wait_pwr(5'h16, 20);
    // latching everywhere, so only the status write may restart
    wr8(8'h21, 8'h3e);
    foreach (order[i]) begin
      b = order[i];
      r = rnd();
      for (int k = 0; k < 3; k++)
        sty_m[2*k +: 2] = 2'((r >> (2*k)) % 3);
      prop_m = {2'h0, r[13:8]};
      prop_m[b] = ~i[0];
      wr8(8'h20, {2'h0, sty_m});
      wr8(`PFT_ADDR_PROP, prop_m);
      det[7:6] <= r[17:16];
      det[b] <= 1'h1;
      c0 = rx_cnt;
      wait_pwr(pwr_of(style_of(b)), 20);
      rd8(`PFT_ADDR_STAT, {~r[17:16], 6'h3f} & ~(8'h01 << b));
      n = 0;
      while (rx_cnt == c0 && n < 200) begin
        @(posedge clk);
        n++;
      end
      // the last style slot is still on the wire when the frame is counted
      repeat (4) @(posedge clk);
      #1;
      tally((rx_cnt != c0) !== prop_m[b], "frame count");
      tally(ok_oe !== prop_m[b], "ok pull");
      if (prop_m[b])
        cmp_sty(rx_style, style_of(b));
      det[b] <= 1'h0;
      repeat (100) @(posedge clk);
      #1;
      cmp_pwr(pwr, pwr_of(style_of(b)));
      wr8(`PFT_ADDR_STAT, 8'h01 << b);
      wait_pwr(5'h16, 600);
    end
    wr8(8'h21, 8'h00);
    det[2] <= 1'h1;
    wait_pwr(pwr_of(sty_m[3:2]), 20);
    det[2] <= 1'h0;
    // still inside the retry interval although the cause is gone
    repeat (40) @(posedge clk);
    #1;
    cmp_pwr(pwr, pwr_of(sty_m[3:2]));
    wait_pwr(5'h16, 600);
    rd8(`PFT_ADDR_STAT, {~r[17:16], 6'h3f});
    for (int s = 0; s < 3; s++) begin
      mgr_u.send_frame(2'(s));
      wait_pwr(pwr_of(2'(s)), 200);
      mgr_u.release_line();
      wait_pwr(5'h16, 600);
    end
    give_verdict();
  end
endmodule : pft_fault_top_test
